// file: hw/acs_regs.v
// Register bank of the sensor ADC: power, restart, auxiliary, result and scan registers
//
// Overview of operation
// - Writing power field: 0 active, 1 power-down, 3 standby request.
// - Reading power field gives state in effect; active after reset.
// - Writing one to restart bit zero aborts and restarts conversion.
// - Calibration-clear bit set makes soft reset also clear calibration.
// - Clock-detect bypass bit set disables external clock detection.
// - Clock-source bit picks external clock, only while bypass set.
// - Four-bit excitation code, 100 uA steps up to 0xA.
// - Ready register reads 0xFF without new data, else 0x00.
// - Result is 16-bit two's complement; high byte 0x1A, low 0x1B.
// - Pending flag is one while scan update is pending; host waits.
// - Stale flag zero if the last low-byte read got a fresh result, one otherwise.
// - Two-bit scan mode: single, single scan, continuous, burnout.
// - Three-bit final channel, 0 to 6, default 6.
// - Scan write with channel code 7 in either field is discarded.
// - Three-bit starting channel in bits 2:0, default channel zero.
// - Writing 0xC3 to reset register resets all registers but the result, and conversion.
`timescale 1ns/1ps
`include "acs_regs_map.vh"

module acs_regs (
	// Clock and reset
	input  wire       clock_in,
	input  wire       rst_b_in,
	// Register access from the serial interface
	input  wire [6:0] reg_addr_in,
	input  wire       reg_wr_in,
	input  wire       reg_rd_in,
	input  wire [7:0] reg_wdata_in,
	output reg  [7:0] reg_rdata_out,
	// Converter side
	input  wire       conv_done_in,
	input  wire [15:0] conv_data_in,
	input  wire [1:0] power_state_in,
	input  wire       seq_adopted_in,
	output wire [1:0] power_request_out,
	output wire       conv_restart_out,
	output wire       soft_reset_out,
	output wire       clear_calibration_out,
	output wire       clock_detect_enable_out,
	output wire       external_clock_sel_out,
	output wire [3:0] excitation_current_code_out,
	output wire [1:0] sequence_mode_select_out,
	output wire [2:0] final_channel_out,
	output wire [2:0] starting_channel_out
);

	reg        rst_meta_q;
	reg        rst_sync_q;
	reg [1:0]  power_req_q;
	reg [7:0]  aux_q;
	reg [7:0]  seq_q;
	reg        pending_q;
	reg        stale_q;
	reg        fresh_q;
	reg [15:0] result_q;
	reg        restart_q;
	reg        soft_rst_q;
	reg        cal_clr_q;
	reg        det_en_q;
	reg        ext_sel_q;
	reg [3:0]  code_q;
	reg [7:0]  rdata_d;
	wire       rst_n;
	wire       wr_power;
	wire       wr_aux;
	wire       wr_seq;
	wire       seq_ok;
	wire       rd_low;
	wire       soft_hit;
	wire       wr_restart;
	wire       restart_hit;
	wire       power_ok;
	wire       seq_accept;

	// Reset release through two flops
	always @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	assign wr_power = reg_wr_in && (reg_addr_in == `ACS_ADDR_POWER);
	assign wr_aux   = reg_wr_in && (reg_addr_in == `ACS_ADDR_AUX);
	assign wr_seq   = reg_wr_in && (reg_addr_in == `ACS_ADDR_SEQ_CONFIG);
	assign seq_ok   = (reg_wdata_in[5:3] != `ACS_CHAN_INVALID) &&
	                  (reg_wdata_in[2:0] != `ACS_CHAN_INVALID);
	assign soft_hit = reg_wr_in && (reg_addr_in == `ACS_ADDR_SOFT_RESET) &&
	                  (reg_wdata_in == `ACS_SOFT_RESET_KEY);
	// Low byte read closes a result read; high byte alone is not counted
	assign rd_low   = reg_rd_in && (reg_addr_in == `ACS_ADDR_RES_LOW);
	assign wr_restart  = reg_wr_in && (reg_addr_in == `ACS_ADDR_RESTART);
	// Code 2 has no meaning, so such a write leaves the request alone
	assign power_ok    = wr_power && (reg_wdata_in[1:0] != 2'h2);
	// A pending update also locks the config against the host
	assign seq_accept  = wr_seq && seq_ok && !pending_q;
	assign restart_hit = (wr_restart && reg_wdata_in[0]) || soft_hit;

	// Restart request, one cycle wide
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= restart_hit;
		end
	end

	// Soft reset pulse towards the converter, one cycle wide
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= soft_hit;
		end
	end

	// Option bit is sampled before the command returns it to zero
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			cal_clr_q <= 1'b0;
		end else begin
			cal_clr_q <= soft_hit && aux_q[`ACS_AUX_CALCLR_BIT];
		end
	end

	// Power request; the soft reset command returns it to active
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			power_req_q <= `ACS_POWER_ACTIVE;
		end else if (soft_hit) begin
			power_req_q <= `ACS_POWER_ACTIVE;
		end else if (power_ok) begin
			power_req_q <= reg_wdata_in[1:0];
		end
	end

	// Auxiliary settings; bit 7 is reserved and held at zero
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			aux_q <= `ACS_AUX_RESET;
		end else if (soft_hit) begin
			aux_q <= `ACS_AUX_RESET;
		end else if (wr_aux) begin
			aux_q <= {1'b0, reg_wdata_in[6:0]};
		end
	end

	// Scan configuration; a refused write leaves every field alone
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			seq_q <= `ACS_SEQ_RESET;
		end else if (soft_hit) begin
			seq_q <= `ACS_SEQ_RESET;
		end else if (seq_accept) begin
			seq_q <= reg_wdata_in;
		end
	end

	// Pending flag: an accepted write wins over an adoption in the same cycle
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			pending_q <= 1'b0;
		end else if (soft_hit) begin
			pending_q <= 1'b0;
		end else if (seq_accept) begin
			pending_q <= 1'b1;
		end else if (seq_adopted_in) begin
			pending_q <= 1'b0;
		end
	end

	// Result data survives the soft reset command
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			result_q <= 16'h0000;
		end else if (conv_done_in) begin
			result_q <= conv_data_in;
		end
	end

	// Fresh flag: new data wins over a low-byte read in the same cycle
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			fresh_q <= 1'b0;
		end else if (soft_hit) begin
			fresh_q <= 1'b0;
		end else if (conv_done_in) begin
			fresh_q <= 1'b1;
		end else if (rd_low) begin
			fresh_q <= 1'b0;
		end
	end

	// Stale flag judges the result read that has just finished
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			stale_q <= 1'b1;
		end else if (soft_hit) begin
			stale_q <= 1'b1;
		end else if (rd_low) begin
			stale_q <= !fresh_q;
		end
	end

	// Read multiplexer; unmapped and write-only addresses read as zero
	always @* begin
		rdata_d = 8'h00;
		case (reg_addr_in)
			`ACS_ADDR_POWER: begin
				rdata_d = {6'h00, power_state_in};
			end
			`ACS_ADDR_AUX: begin
				rdata_d = aux_q;
			end
			`ACS_ADDR_READY: begin
				rdata_d = fresh_q ? `ACS_READY_NEW : `ACS_READY_NONE;
			end
			`ACS_ADDR_RES_HIGH: begin
				rdata_d = result_q[15:8];
			end
			`ACS_ADDR_RES_LOW: begin
				rdata_d = result_q[7:0];
			end
			`ACS_ADDR_SEQ_STATUS: begin
				// Status and low byte share no address, so no bypass is needed
				rdata_d = {6'h00, pending_q, stale_q};
			end
			`ACS_ADDR_SEQ_CONFIG: begin
				rdata_d = seq_q;
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// Read data is registered and held until the next read
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rdata_d;
		end
	end

	// Detection stays on unless the bypass bit is set
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			det_en_q <= 1'b1;
		end else begin
			det_en_q <= !aux_q[`ACS_AUX_BYPASS_BIT];
		end
	end

	// Clock source only honoured while detection is bypassed
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			ext_sel_q <= 1'b0;
		end else begin
			ext_sel_q <= aux_q[`ACS_AUX_BYPASS_BIT] && aux_q[`ACS_AUX_CLKSEL_BIT];
		end
	end

	// Codes above the top step saturate, so the source is never overdriven
	always @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			code_q <= 4'h0;
		end else if (aux_q[3:0] > `ACS_CUR_CODE_MAX) begin
			code_q <= `ACS_CUR_CODE_MAX;
		end else begin
			code_q <= aux_q[3:0];
		end
	end

	assign power_request_out           = power_req_q;
	assign conv_restart_out            = restart_q;
	assign soft_reset_out              = soft_rst_q;
	assign clear_calibration_out       = cal_clr_q;
	assign clock_detect_enable_out     = det_en_q;
	assign external_clock_sel_out      = ext_sel_q;
	assign excitation_current_code_out = code_q;
	assign sequence_mode_select_out    = seq_q[7:6];
	assign final_channel_out           = seq_q[5:3];
	assign starting_channel_out        = seq_q[2:0];

endmodule

// file: hw/acs_regs_map.vh
// Register offsets, field positions and reset values of the ADC register bank
`ifndef ACS_REGS_MAP_VH
`define ACS_REGS_MAP_VH

`define ACS_ADDR_SOFT_RESET   7'h00
`define ACS_ADDR_POWER        7'h08
`define ACS_ADDR_RESTART      7'h0b
`define ACS_ADDR_AUX          7'h12
`define ACS_ADDR_READY        7'h18
`define ACS_ADDR_RES_HIGH     7'h1a
`define ACS_ADDR_RES_LOW      7'h1b
`define ACS_ADDR_SEQ_STATUS   7'h1e
`define ACS_ADDR_SEQ_CONFIG   7'h1f

`define ACS_SOFT_RESET_KEY    8'hc3
`define ACS_POWER_ACTIVE      2'h0
`define ACS_POWER_DOWN        2'h1
`define ACS_POWER_STANDBY     2'h3
`define ACS_AUX_RESET         8'h00
`define ACS_AUX_CALCLR_BIT    6
`define ACS_AUX_BYPASS_BIT    5
`define ACS_AUX_CLKSEL_BIT    4
`define ACS_CUR_CODE_MAX      4'ha
`define ACS_READY_NONE        8'hff
`define ACS_READY_NEW         8'h00
`define ACS_SEQ_RESET         8'h30
`define ACS_CHAN_INVALID      3'h7
`define ACS_PENDING_BIT       1
`define ACS_STALE_BIT         0

`endif

// file: bench/acs_core_model.sv
// Behavioural analog core that sits behind the register bank
`timescale 1ns/1ps
module acs_core_model (
	// Requests from the bank and from the bench
	input  wire        clock_in,
	input  wire [1:0]  power_request_out,
	input  wire [15:0] sample,
	input  wire        make_result,
	input  wire        adopt,
	// Status back to the bank
	output logic [1:0]  power_state_in,
	output logic        conv_done_in,
	output logic [15:0] conv_data_in,
	output logic        seq_adopted_in
);
	initial {power_state_in, conv_done_in, conv_data_in, seq_adopted_in} = '0;
	always @(negedge clock_in) begin
		power_state_in <= power_request_out;
		conv_done_in <= make_result;
		// Data bus churns when no result is offered
		conv_data_in <= make_result ? sample : ~conv_data_in;
		seq_adopted_in <= adopt;
	end
endmodule

// file: bench/acs_regs_props.sv
// Port assertions of the register bank
`timescale 1ns/1ps
module acs_regs_props (
	// Clock, reset and register writes
	input wire clock_in, rst_b_in, reg_wr_in,
	input wire [6:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	// Converter controls
	input wire [1:0] power_request_out,
	input wire conv_restart_out, soft_reset_out, clear_calibration_out,
	input wire clock_detect_enable_out, external_clock_sel_out,
	input wire [3:0] excitation_current_code_out,
	input wire [2:0] final_channel_out, starting_channel_out
);
	wire [7:0] d = reg_wdata_in;
	wire key = reg_wr_in && reg_addr_in == 7'h00 && d == 8'hc3;
	wire scan = reg_wr_in && reg_addr_in == 7'h1f;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	restart_pulse_a:
	assert property (reg_wr_in && reg_addr_in == 7'h0b && d[0] |=> conv_restart_out) else $error("no restart");
	soft_reset_a:
	assert property (key |=> soft_reset_out && conv_restart_out) else $error("no soft reset");
	soft_cause_a:
	assert property (soft_reset_out |-> $past(key)) else $error("stray soft reset");
	cal_clear_a:
	assert property (clear_calibration_out |-> soft_reset_out) else $error("stray cal clear");
	power_req_a:
	assert property (reg_wr_in && reg_addr_in == 7'h08 && d[1:0] != 2'h2
		|=> power_request_out == $past(d[1:0])) else $error("power request wrong");
	scan_drop_a:
	assert property (scan && (d[5:3] == 3'h7 || d[2:0] == 3'h7)
		|=> $stable(final_channel_out) && $stable(starting_channel_out)) else $error("bad scan kept");
	chan_range_a:
	assert property (final_channel_out != 3'h7 && starting_channel_out != 3'h7) else $error("channel 7");
	clock_sel_a:
	assert property (external_clock_sel_out |-> !clock_detect_enable_out) else $error("clock select");
	code_max_a:
	assert property (excitation_current_code_out <= 4'ha) else $error("current code high");
	cover property (key);
	cover property (clear_calibration_out);
	cover property (scan);
endmodule
bind acs_regs acs_regs_props i_props (.*);

// file: bench/tb_top.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
	logic clock_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0, make_result = 0, adopt = 0;
	logic conv_done_in, seq_adopted_in, conv_restart_out, soft_reset_out, clear_calibration_out;
	logic clock_detect_enable_out, external_clock_sel_out;
	logic [6:0] reg_addr_in = 0;
	logic [7:0] reg_wdata_in = 0, reg_rdata_out, pw[4] = '{1, 3, 2, 0}, pe[4] = '{1, 3, 3, 0};
	logic [15:0] conv_data_in, sample = 16'h8001;
	logic [1:0] power_state_in, power_request_out, sequence_mode_select_out;
	logic [3:0] excitation_current_code_out;
	logic [2:0] final_channel_out, starting_channel_out;
	int num_errors = 0, tests_run = 0, cal_seen = 0, rst_seen = 0;
	always @(posedge clock_in) begin
		cal_seen += clear_calibration_out;
		rst_seen += conv_restart_out;
	end
	acs_regs i_dut (.*);
	acs_core_model i_core (.*);
	always #10 clock_in = ~clock_in;
	task check(input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [6:0] a, input logic [7:0] v);
		@(negedge clock_in) {reg_wr_in, reg_addr_in, reg_wdata_in} = {1'b1, a, v};
		@(negedge clock_in) reg_wr_in = 0;
		@(negedge clock_in);
	endtask
	task rd(input logic [6:0] a, input logic [7:0] exp);
		@(negedge clock_in) {reg_rd_in, reg_addr_in} = {1'b1, a};
		@(negedge clock_in) reg_rd_in = 0;
		@(negedge clock_in) check(reg_rdata_out, exp);
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clock_in);
		rst_b_in = 1;
		repeat (3) @(negedge clock_in);
		rd(7'h08, 8'h00);
		rd(7'h1f, 8'h30);
		rd(7'h18, 8'hff);
		rd(7'h1e, 8'h01);
		rd(7'h1c, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(7'h08, pw[i]);
			check({6'h0, power_request_out}, pe[i]);
			rd(7'h08, pe[i]);
		end
		$display("test reset and power done");
		wr(7'h12, 8'h3c);
		check({4'h0, excitation_current_code_out}, 8'h0a);
		check({7'h0, external_clock_sel_out, clock_detect_enable_out}, 8'h02);
		wr(7'h12, 8'h14);
		check({7'h0, external_clock_sel_out, clock_detect_enable_out}, 8'h01);
		rd(7'h12, 8'h14);
		wr(7'h12, 8'h40);
		wr(7'h00, 8'h55);
		check(8'(rst_seen), 8'h00);
		rd(7'h12, 8'h40);
		wr(7'h00, 8'hc3);
		check(8'(cal_seen), 8'h01);
		check(8'(rst_seen), 8'h01);
		rd(7'h12, 8'h00);
		wr(7'h0b, 8'h01);
		check(8'(rst_seen), 8'h02);
		wr(7'h00, 8'hc3);
		check(8'(cal_seen), 8'h01);
		check(8'(rst_seen), 8'h03);
		$display("test auxiliary and reset done");
		for (int m = 0; m < 4; m++) begin
			wr(7'h1f, {m[1:0], 6'h1a});
			check({sequence_mode_select_out, final_channel_out, starting_channel_out}, {m[1:0], 6'h1a});
			rd(7'h1e, 8'h03);
			wr(7'h1f, 8'h00);
			adopt <= 1;
			@(negedge clock_in) adopt <= 0;
			rd(7'h1e, 8'h01);
			rd(7'h1f, {m[1:0], 6'h1a});
		end
		wr(7'h1f, 8'h38);
		wr(7'h1f, 8'hc7);
		rd(7'h1f, 8'hda);
		rd(7'h1e, 8'h01);
		$display("test scan done");
		make_result <= 1;
		@(negedge clock_in) make_result <= 0;
		rd(7'h18, 8'h00);
		rd(7'h1a, 8'h80);
		repeat (3600) @(negedge clock_in);
		rd(7'h1b, 8'h01);
		rd(7'h1e, 8'h00);
		repeat (3600) @(negedge clock_in);
		rd(7'h1b, 8'h01);
		rd(7'h1e, 8'h01);
		rd(7'h18, 8'hff);
		$display("test result done");
		test_done();
	end
endmodule
